/* File: rtl/reset_clock_irq_consts.svh */
// constants for the reset, bus-phase clock and interrupt request pin logic
//
// Function
// - low reset pin asserts system reset, which clears the sense selection and pending edge
// - open-drain reset drive on monitor or watchdog failure
// - pin high within two cycles means internal
// - bus-phase clock is oscillator divided by four
// - low phase processing, high phase bus access
// - stop mode halts the bus-phase clock and clock output, not the oscillator drive
// - clock output disable only in single-chip modes
// - request input synchronized before internal use
// - configuration bit selects falling edge or level
// - sense selection returns to level on reset
// - in level mode, a low line reinterrupts once mask clears
`ifndef RESET_CLOCK_IRQ_CONSTS_SVH
`define RESET_CLOCK_IRQ_CONSTS_SVH

// ==========================================
// clock division
`define OSC_DIV_RATIO     3'h4
`define PHASE_CNT_LAST    2'h3
`define PHASE_HIGH_FIRST  2'h2

// ==========================================
// reset timing, in bus-phase cycles
`define FAIL_HOLD_CYCLES  8'h04
`define DISCRIM_CYCLES    8'h02

// ==========================================
// reset values
`define SENSE_RESET_LEVEL 1'h0

`endif

/* File: rtl/reset_clock_irq_pkg.sv */
// types shared by the reset, clock and interrupt request pin logic
package reset_clock_irq_pkg;

    typedef enum logic [3:0] {
        RST_IDLE    = 4'h1,
        RST_DRIVE   = 4'h2,
        RST_RELEASE = 4'h4,
        RST_WAIT_HI = 4'h8
    } rst_state_e;

endpackage

/* File: rtl/phase_if.sv */
// bus-phase timing signals shared between the divider and the pin logic
`timescale 1ns/100ps
interface phase_if;
    logic e_tick;
    logic e_phase;
    logic run;
    modport source (output e_tick, output e_phase, input run);
    modport sink   (input e_tick, input e_phase, output run);
endinterface

/* File: rtl/bus_phase_divider.sv */
// divide-by-four bus-phase clock generator
`timescale 1ns/100ps
`include "reset_clock_irq_consts.svh"
module bus_phase_divider (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    phase_if.source   ph
);
    logic [1:0] phase_cnt;
    logic [1:0] next_phase_cnt;

    assign next_phase_cnt = (phase_cnt == `PHASE_CNT_LAST) ? 2'h0 : phase_cnt + 2'h1;

    // counter freezes while stopped, no phase advances
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_cnt <= 2'h0;
        end else if (ph.run) begin
            phase_cnt <= next_phase_cnt;
        end
    end

    // first half low (processing), second half high (access)
    assign ph.e_phase = (phase_cnt >= `PHASE_HIGH_FIRST);
    assign ph.e_tick  = ph.run && (phase_cnt == `PHASE_CNT_LAST);

    property p_div_period;
        @(posedge ref_clk) disable iff (!rst_n)
        (ph.e_tick && ph.run) ##1 ph.run [*4] |-> ph.e_tick && !$past(ph.e_tick, 1);
    endproperty
    a_div_period: assert property (p_div_period) else $error("phase period not four");
endmodule

/* File: rtl/reset_clock_irq_pins.sv */
// reset pin, bus-phase clock output and interrupt request input logic
`timescale 1ns/100ps
`include "reset_clock_irq_consts.svh"
module reset_clock_irq_pins (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic osc_clock_in,
    input  wire logic reset_pin_in,
    input  wire logic clock_monitor_fail,
    input  wire logic watchdog_supervisor_fail,
    input  wire logic stop_mode,
    input  wire logic single_chip_mode,
    input  wire logic clk_out_disable,
    input  wire logic irq_pin_n,
    input  wire logic sense_edge_wr,
    input  wire logic sense_edge_val,
    input  wire logic irq_mask,
    input  wire logic irq_taken,
    output logic      osc_drive_out,
    output logic      reset_pin_out,
    output logic      reset_pin_oe,
    output logic      sys_reset_n,
    output logic      reset_internal,
    output logic      reset_class_valid,
    output logic      e_clk_out,
    output logic      phase_access,
    output logic      sense_edge,
    output logic      irq_request
);
    phase_if ph ();

    bus_phase_divider u_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ph      (ph)
    );

    // ==========================================
    // clock gating and phase outputs
    logic e_gate;
    assign ph.run = !stop_mode;
    // disable honoured only in single-chip modes
    assign e_gate = ph.run && !(clk_out_disable && single_chip_mode);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            e_clk_out     <= 1'b0;
            phase_access  <= 1'b0;
            osc_drive_out <= 1'b0;
        end else begin
            e_clk_out     <= e_gate && ph.e_phase;
            phase_access  <= ph.e_phase;
            osc_drive_out <= !osc_clock_in;
        end
    end

    // ==========================================
    // reset pin state machine
    reset_clock_irq_pkg::rst_state_e state;
    reset_clock_irq_pkg::rst_state_e next_state;
    logic [7:0] cyc;
    logic       fail;
    logic       pin_low;
    logic       cyc_done;
    logic       discrim_done;

    assign fail         = clock_monitor_fail || watchdog_supervisor_fail;
    assign pin_low      = !reset_pin_in;
    assign cyc_done     = ph.e_tick && (cyc == `FAIL_HOLD_CYCLES - 8'h01);
    assign discrim_done = ph.e_tick && (cyc == `DISCRIM_CYCLES - 8'h01);

    always_comb begin
        next_state = state;
        case (state)
            reset_clock_irq_pkg::RST_IDLE: begin
                if (fail) begin
                    next_state = reset_clock_irq_pkg::RST_DRIVE;
                end else if (pin_low) begin
                    next_state = reset_clock_irq_pkg::RST_WAIT_HI;
                end
            end
            reset_clock_irq_pkg::RST_DRIVE: begin
                if (cyc_done) begin
                    next_state = reset_clock_irq_pkg::RST_RELEASE;
                end
            end
            reset_clock_irq_pkg::RST_RELEASE: begin
                if (!pin_low) begin
                    next_state = reset_clock_irq_pkg::RST_IDLE;
                end else if (discrim_done) begin
                    next_state = reset_clock_irq_pkg::RST_WAIT_HI;
                end
            end
            reset_clock_irq_pkg::RST_WAIT_HI: begin
                if (!pin_low) begin
                    next_state = reset_clock_irq_pkg::RST_IDLE;
                end
            end
            default: next_state = reset_clock_irq_pkg::RST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= reset_clock_irq_pkg::RST_IDLE;
            cyc   <= 8'h00;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                cyc <= 8'h00;
            end else if (ph.e_tick) begin
                cyc <= cyc + 8'h01;
            end
        end
    end

    // open-drain: only ever drives low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pin_oe      <= 1'b0;
            reset_pin_out     <= 1'b0;
            sys_reset_n       <= 1'b0;
            reset_internal    <= 1'b0;
            reset_class_valid <= 1'b0;
        end else begin
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= (next_state == reset_clock_irq_pkg::RST_DRIVE);
            sys_reset_n   <= (next_state == reset_clock_irq_pkg::RST_IDLE) && !pin_low;
            if (state == reset_clock_irq_pkg::RST_RELEASE && !pin_low) begin
                reset_internal    <= 1'b1;
                reset_class_valid <= 1'b1;
            end else if (state == reset_clock_irq_pkg::RST_WAIT_HI && !pin_low) begin
                reset_internal    <= 1'b0;
                reset_class_valid <= 1'b1;
            end else if (state == reset_clock_irq_pkg::RST_IDLE && (fail || pin_low)) begin
                reset_class_valid <= 1'b0;
            end
        end
    end

    // ==========================================
    // interrupt request input
    logic irq_s1;
    logic irq_s2;
    logic irq_s3;
    logic pend;
    logic fall;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1 <= 1'b1;
            irq_s2 <= 1'b1;
            irq_s3 <= 1'b1;
        end else begin
            irq_s1 <= irq_pin_n;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
        end
    end

    assign fall = irq_s3 && !irq_s2;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_edge <= `SENSE_RESET_LEVEL;
            pend       <= 1'b0;
        end else if (!sys_reset_n) begin
            sense_edge <= `SENSE_RESET_LEVEL;
            pend       <= 1'b0;
        end else begin
            if (sense_edge_wr) begin
                sense_edge <= sense_edge_val;
            end
            // new edge wins over the take
            if (sense_edge && fall) begin
                pend <= 1'b1;
            end else if (irq_taken || !sense_edge) begin
                pend <= 1'b0;
            end
        end
    end

    // level mode re-asserts whenever mask clears with line low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= !irq_mask && (sense_edge ? pend : !irq_s2);
        end
    end

    // ==========================================
    // checks
    property p_never_high;
        @(posedge ref_clk) disable iff (!rst_n)
        reset_pin_oe |-> reset_pin_out == 1'b0;
    endproperty
    a_never_high: assert property (p_never_high) else $error("reset pin driven high");

    property p_drive_cause;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(reset_pin_oe) |-> $past(fail, 1);
    endproperty
    a_drive_cause: assert property (p_drive_cause) else $error("pin driven without failure");

    property p_fail_drive;
        @(posedge ref_clk) disable iff (!rst_n)
        (state == reset_clock_irq_pkg::RST_IDLE && fail) |=> reset_pin_oe;
    endproperty
    a_fail_drive: assert property (p_fail_drive) else $error("failure did not drive pin");

    property p_ext_reset;
        @(posedge ref_clk) disable iff (!rst_n)
        (pin_low && state != reset_clock_irq_pkg::RST_DRIVE) |=> !sys_reset_n;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("low pin did not reset");

    property p_internal_class;
        @(posedge ref_clk) disable iff (!rst_n)
        (state == reset_clock_irq_pkg::RST_RELEASE && !pin_low) |=> reset_internal && reset_class_valid;
    endproperty
    a_internal_class: assert property (p_internal_class) else $error("internal reset misclassed");

    property p_stop_halts;
        @(posedge ref_clk) disable iff (!rst_n)
        stop_mode ##1 stop_mode |-> !e_clk_out && !ph.e_tick;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("clock ran in stop");

    property p_disable_sc;
        @(posedge ref_clk) disable iff (!rst_n)
        (!single_chip_mode && !stop_mode && ph.e_phase) |=> e_clk_out;
    endproperty
    a_disable_sc: assert property (p_disable_sc) else $error("clock gated outside single chip");

    property p_sync_delay;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(irq_s2) && !sense_edge && !irq_mask |=> irq_request;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("level request not raised");

    property p_edge_pend;
        @(posedge ref_clk) disable iff (!rst_n)
        (sense_edge && fall && sys_reset_n) |=> pend;
    endproperty
    a_edge_pend: assert property (p_edge_pend) else $error("edge not latched");

    property p_sense_reset;
        @(posedge ref_clk) disable iff (!rst_n)
        !sys_reset_n |=> sense_edge == `SENSE_RESET_LEVEL;
    endproperty
    a_sense_reset: assert property (p_sense_reset) else $error("sense not level after reset");
endmodule

/* File: test/far_side_model.sv */
// far-side model: pulled-up reset wire, external reset source, held interrupt source
`timescale 1ns/100ps
module far_side_model (
    input  wire logic ref_clk,
    input  wire logic reset_pin_oe,
    input  wire logic reset_pin_out,
    input  wire logic ext_reset,
    input  wire logic irq_raise,
    input  wire logic irq_ack,
    output logic      reset_pin_in,
    output logic      irq_pin_n
);
    logic irq_hold = 1'h0;

    // ==========================================
    // wire level
    // pull-up, so only a low drive or the switch changes the level
    assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || ext_reset);
    assign irq_pin_n    = !irq_hold;

    // ==========================================
    // interrupt source interlock
    // line stays low until the source is acknowledged
    always @(posedge ref_clk) begin
        if (irq_raise) begin
            irq_hold <= 1'h1;
        end else if (irq_ack) begin
            irq_hold <= 1'h0;
        end
    end
endmodule

/* File: test/reset_clock_irq_pins_tb.sv */
// self-checking testbench for the reset, bus-phase clock and interrupt request pin logic
`timescale 1ns/100ps
module reset_clock_irq_pins_tb;
    typedef struct packed {logic stop; logic single; logic dis; logic [4:0] highs;} clk_row_s;
    logic ref_clk = 1'h0, rst_n = 1'h0, osc_clock_in = 1'h0;
    logic clock_monitor_fail = 1'h0, watchdog_supervisor_fail = 1'h0, stop_mode = 1'h0;
    logic single_chip_mode = 1'h0, clk_out_disable = 1'h0, sense_edge_wr = 1'h0;
    logic sense_edge_val = 1'h0, irq_mask = 1'h0, irq_taken = 1'h0;
    logic ext_reset = 1'h0, irq_raise = 1'h0, irq_ack = 1'h0;
    logic reset_pin_in, irq_pin_n, osc_drive_out, reset_pin_out, reset_pin_oe, sys_reset_n;
    logic reset_internal, reset_class_valid, e_clk_out, phase_access, sense_edge, irq_request;
    int   err_total = 0, num_checks = 0, cycles = 0, hi, ph, n;
    clk_row_s rows[5] = '{'{1'h0, 1'h0, 1'h0, 5'h08}, '{1'h1, 1'h0, 1'h0, 5'h00},
                          '{1'h0, 1'h1, 1'h1, 5'h00}, '{1'h0, 1'h0, 1'h1, 5'h08},
                          '{1'h0, 1'h1, 1'h0, 5'h08}};

    reset_clock_irq_pins DUT (.ref_clk(ref_clk), .rst_n(rst_n), .osc_clock_in(osc_clock_in),
        .reset_pin_in(reset_pin_in), .clock_monitor_fail(clock_monitor_fail),
        .watchdog_supervisor_fail(watchdog_supervisor_fail), .stop_mode(stop_mode),
        .single_chip_mode(single_chip_mode), .clk_out_disable(clk_out_disable),
        .irq_pin_n(irq_pin_n), .sense_edge_wr(sense_edge_wr), .sense_edge_val(sense_edge_val),
        .irq_mask(irq_mask), .irq_taken(irq_taken), .osc_drive_out(osc_drive_out),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .sys_reset_n(sys_reset_n),
        .reset_internal(reset_internal), .reset_class_valid(reset_class_valid),
        .e_clk_out(e_clk_out), .phase_access(phase_access), .sense_edge(sense_edge),
        .irq_request(irq_request));

    far_side_model far (.ref_clk(ref_clk), .reset_pin_oe(reset_pin_oe),
        .reset_pin_out(reset_pin_out), .ext_reset(ext_reset), .irq_raise(irq_raise),
        .irq_ack(irq_ack), .reset_pin_in(reset_pin_in), .irq_pin_n(irq_pin_n));

    // ==========================================
    // clock, oscillator input and cycle ceiling
    initial begin
        forever #2.5 ref_clk = !ref_clk;
    end
    always @(posedge ref_clk) begin
        osc_clock_in <= !osc_clock_in;
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(logic got, logic exp, string msg);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic wait_negs(int k);
        repeat (k) @(negedge ref_clk);
    endtask

    task automatic end_of_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        wait_negs(10);
        chk(sys_reset_n, 1'h0, "held in reset");
        chk(sense_edge, 1'h0, "sense not level at reset");
        chk(reset_pin_oe, 1'h0, "pin driven in reset");
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'h1;
        wait_negs(4);
        chk(sys_reset_n, 1'h1, "reset not left");
        // input toggles every rising edge, so its registered inverse equals the present input
        chk(osc_drive_out, osc_clock_in, "oscillator drive not inverse");
        // clock output rows
        foreach (rows[r]) begin
            @(posedge ref_clk);
            stop_mode <= rows[r].stop;
            single_chip_mode <= rows[r].single;
            clk_out_disable <= rows[r].dis;
            wait_negs(8);
            hi = 0;
            ph = 0;
            for (int i = 0; i < 16; i++) begin
                @(negedge ref_clk);
                hi += int'(e_clk_out === 1'h1);
                ph += int'(phase_access === 1'h1);
            end
            chk(hi == int'(rows[r].highs), 1'h1, "clock out high count");
            if (rows[r].highs != 5'h00) chk(ph == 8, 1'h1, "access half length");
        end
        @(posedge ref_clk);
        stop_mode <= 1'h0;
        // failure drive from each source
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk);
            clock_monitor_fail <= (s == 0);
            watchdog_supervisor_fail <= (s == 1);
            @(posedge ref_clk);
            clock_monitor_fail <= 1'h0;
            watchdog_supervisor_fail <= 1'h0;
            n = 0;
            for (int i = 0; i < 40; i++) begin
                @(negedge ref_clk);
                n += int'(reset_pin_oe === 1'h1);
                if (reset_pin_oe === 1'h1) chk(reset_pin_out, 1'h0, "pin driven high");
                if (i == 8) chk(sys_reset_n, 1'h0, "no reset on failure");
            end
            chk(n >= 13 && n <= 16, 1'h1, "failure hold length");
            chk(reset_class_valid, 1'h1, "class not valid");
            chk(reset_internal, 1'h1, "failure not internal");
        end
        // failure while the pin is also held low outside: classed external
        @(posedge ref_clk);
        clock_monitor_fail <= 1'h1;
        ext_reset <= 1'h1;
        @(posedge ref_clk);
        clock_monitor_fail <= 1'h0;
        wait_negs(40);
        @(posedge ref_clk);
        ext_reset <= 1'h0;
        wait_negs(4);
        chk(reset_class_valid, 1'h1, "held pin class not valid");
        chk(reset_internal, 1'h0, "held pin seen as internal");
        // level-sensitive request with mask
        @(posedge ref_clk);
        irq_raise <= 1'h1;
        @(posedge ref_clk);
        irq_raise <= 1'h0;
        wait_negs(5);
        chk(irq_request, 1'h1, "level request missing");
        @(posedge ref_clk);
        irq_mask <= 1'h1;
        wait_negs(3);
        chk(irq_request, 1'h0, "masked request seen");
        @(posedge ref_clk);
        irq_mask <= 1'h0;
        wait_negs(3);
        chk(irq_request, 1'h1, "no request after unmask");
        @(posedge ref_clk);
        irq_ack <= 1'h1;
        @(posedge ref_clk);
        irq_ack <= 1'h0;
        wait_negs(5);
        chk(irq_request, 1'h0, "level request after release");
        // edge-sensitive request latched until taken
        @(posedge ref_clk);
        sense_edge_wr <= 1'h1;
        sense_edge_val <= 1'h1;
        @(posedge ref_clk);
        sense_edge_wr <= 1'h0;
        @(negedge ref_clk);
        chk(sense_edge, 1'h1, "edge sense not set");
        @(posedge ref_clk);
        irq_raise <= 1'h1;
        @(posedge ref_clk);
        irq_raise <= 1'h0;
        repeat (3) @(posedge ref_clk);
        irq_ack <= 1'h1;
        @(posedge ref_clk);
        irq_ack <= 1'h0;
        wait_negs(5);
        chk(irq_request, 1'h1, "edge not latched");
        @(posedge ref_clk);
        irq_taken <= 1'h1;
        @(posedge ref_clk);
        irq_taken <= 1'h0;
        wait_negs(2);
        chk(irq_request, 1'h0, "pending not cleared");
        // external reset on the pin
        @(posedge ref_clk);
        ext_reset <= 1'h1;
        wait_negs(20);
        chk(sys_reset_n, 1'h0, "pin low not reset");
        chk(sense_edge, 1'h0, "sense not back to level");
        @(posedge ref_clk);
        ext_reset <= 1'h0;
        wait_negs(4);
        chk(reset_class_valid, 1'h1, "class not valid");
        chk(reset_internal, 1'h0, "external seen as internal");
        chk(sys_reset_n, 1'h1, "reset not left");
        end_of_test();
    end
endmodule
